/* logic/flash_cycle_engine.sv */
// Purpose: one asynchronous flash read or write cycle on the pins
// Assumes: request held until done; strobe timing set by package counts
// Notes:   reads sample data just before the strobe rises
`timescale 1ns/1ns
`default_nettype none
module flash_cycle_engine
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Request side
  input  wire logic        req,
  input  wire cycle_s      cyc,
  output logic             done,
  output logic [15:0]      rdata_q,
  // Flash pins
  output flash_pins_s      pins,
  input  wire logic [15:0] dq_sync
);

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_LOW  = 2'b01,
    CY_HIGH = 2'b10
  } cy_e;

  cy_e        st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic       wr_q;
  logic [18:0] addr_q;
  logic [15:0] wd_q;

  wire low_end  = (cnt_q == 8'(STROBE_LOW_CYC - 1));
  wire high_end = (cnt_q == 8'(STROBE_HIGH_CYC - 1));
  assign done = (st_q == CY_HIGH) && high_end;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 8'h01;
    case (st_q)
      CY_IDLE: begin
        cnt_d = 8'h00;
        if (req) st_d = CY_LOW;
      end
      CY_LOW: if (low_end) begin
        st_d  = CY_HIGH;
        cnt_d = 8'h00;
      end
      CY_HIGH: if (high_end) begin
        st_d  = CY_IDLE;
        cnt_d = 8'h00;
      end
      default: st_d = CY_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q    <= CY_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wd_q    <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (st_q == CY_IDLE && req) begin
        wr_q   <= cyc.write;
        addr_q <= cyc.addr;
        wd_q   <= cyc.data;
      end
      if (st_q == CY_LOW && low_end && !wr_q) rdata_q <= dq_sync;
    end
  end

  // Strobes return high between cycles so the status latch refreshes
  // Write data captured by the flash on the rising strobe
  wire strobe = (st_q == CY_LOW);
  assign pins.ce_n   = !strobe;
  assign pins.oe_n   = !(strobe && !wr_q);
  assign pins.we_n   = !(strobe && wr_q);
  assign pins.addr   = addr_q;
  assign pins.dq_out = wd_q;
  assign pins.dq_oe  = (st_q != CY_IDLE) && wr_q;

endmodule
`default_nettype wire

/* logic/flash_host.sv */
// Purpose: APB-controlled host sequencer for an asynchronous parallel flash
// Assumes: APB3 slave, word-mode flash, single 100 MHz clock
// Notes:   busy pin and data bus cross through three flip-flops
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module flash_host
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [18:0]      flash_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_out,
  output logic             reset_powerdown_n
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [15:0] dq_s1, dq_s2, dq_s3, dq_q;
  logic [2:0]  rb_s;
  logic        rb_ready_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
      dq_q  <= 16'h0000;
      // Start at the pulled-up idle level so reset shows no false busy
      rb_s  <= 3'h7;
      rb_ready_q <= 1'b1;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      if (dq_s2 == dq_s3) dq_q <= dq_s3;
      rb_s  <= {rb_s[1:0], ready_busy_out};
      // Floating pin is pulled high on board, low means busy
      if (rb_s[1] == rb_s[2]) rb_ready_q <= rb_s[2];
    end
  end

  // ****************************************************************
  // Host sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_CYC1  = 3'b001,
    SQ_CYC2  = 3'b010,
    SQ_WAIT  = 3'b011,
    SQ_POLL  = 3'b100,
    SQ_CHECK = 3'b101
  } sq_e;

  sq_e         sq_q, sq_d;
  op_e         op_q;
  logic [18:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0]  fsr_q;
  logic        busy_q;
  logic        err_q;
  logic        eng_req;
  logic        eng_done;
  logic [15:0] eng_rdata;
  cycle_s      cyc;
  flash_pins_s pins;

  // Two-cycle commands wait for the device, then poll its status
  function automatic logic two_cycle(input op_e op);
    two_cycle = (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE) ||
                (op == OP_PROGRAM);
  endfunction

  function automatic logic [7:0] first_code(input op_e op);
    case (op)
      OP_READ_ARRAY:   first_code = CMD_READ_ARRAY;
      OP_READ_ID:      first_code = CMD_READ_ID;
      OP_READ_STATUS:  first_code = CMD_READ_STATUS;
      OP_CLEAR_STATUS: first_code = CMD_CLEAR_STATUS;
      OP_BLOCK_ERASE:  first_code = CMD_BLOCK_ERASE;
      OP_CHIP_ERASE:   first_code = CMD_CHIP_ERASE;
      OP_PROGRAM:      first_code = CMD_PROGRAM;
      default:         first_code = 8'h00;
    endcase
  endfunction

  // Second cycle: confirm, program data, or a read for read-type ops
  wire [15:0] confirm_word = {8'h00, CMD_CONFIRM};
  wire [15:0] second_data  =
    (op_q == OP_PROGRAM) ? wdata_q : confirm_word;
  wire        second_is_rd = !two_cycle(op_q);
  wire        raw_op       = (op_q == OP_RAW_WRITE);

  always_comb begin
    cyc.write = 1'b1;
    cyc.addr  = addr_q;
    cyc.data  = raw_op ? wdata_q : {8'h00, first_code(op_q)};
    eng_req   = 1'b0;
    case (sq_q)
      SQ_CYC1: eng_req = 1'b1;
      SQ_CYC2: begin
        eng_req   = 1'b1;
        cyc.write = !second_is_rd;
        cyc.data  = second_data;
      end
      SQ_POLL: begin
        eng_req   = 1'b1;
        cyc.write = 1'b0;
      end
      default: eng_req = 1'b0;
    endcase
  end

  // Completion seen on the busy pin, then confirmed by the ready bit
  wire dev_ready = eng_rdata[SR_READY_BIT];
  wire any_err   = |{eng_rdata[SR_ERASE_BIT], eng_rdata[SR_PROG_BIT],
                     eng_rdata[SR_SUPPLY_BIT], eng_rdata[SR_LOCK_BIT]};

  always_comb begin
    sq_d = sq_q;
    case (sq_q)
      SQ_IDLE:  sq_d = SQ_IDLE;
      SQ_CYC1:  if (eng_done)
                  sq_d = (raw_op || op_q == OP_CLEAR_STATUS) ?
                         SQ_IDLE : SQ_CYC2;
      SQ_CYC2:  if (eng_done)
                  sq_d = second_is_rd ? SQ_IDLE : SQ_WAIT;
      SQ_WAIT:  if (rb_ready_q) sq_d = SQ_POLL;
      SQ_POLL:  if (eng_done) sq_d = SQ_CHECK;
      SQ_CHECK: sq_d = dev_ready ? SQ_IDLE : SQ_POLL;
      default:  sq_d = SQ_IDLE;
    endcase
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  wire apb_wr   = psel && penable && pwrite;
  wire go_write = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_GO_BIT];
  wire start    = go_write && !busy_q;
  wire hit_known = (paddr == REG_CTRL) || (paddr == REG_ADDR) ||
                   (paddr == REG_WDATA) || (paddr == REG_STATUS) ||
                   (paddr == REG_RDATA) || (paddr == REG_FSR);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_known;

  always_comb begin
    case (paddr)
      REG_CTRL:   prdata = {29'h0, op_q};
      REG_ADDR:   prdata = {13'h0, addr_q};
      REG_WDATA:  prdata = {16'h0, wdata_q};
      REG_STATUS: prdata = {29'h0, rb_ready_q, err_q, busy_q};
      // Upper byte of ID and status reads arrives as zero
      REG_RDATA:  prdata = {16'h0, rdata_q};
      // Sticky error flags as last read from the device
      REG_FSR:    prdata = {24'h0, fsr_q};
      default:    prdata = RESET_WORD;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sq_q    <= SQ_IDLE;
      op_q    <= OP_READ_ARRAY;
      addr_q  <= 19'h0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      fsr_q   <= 8'h00;
      busy_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      sq_q <= start ? SQ_CYC1 : sq_d;
      if (start) begin
        op_q   <= op_e'(pwdata[CTRL_OP_LSB +: 3]);
        busy_q <= 1'b1;
      end else if (sq_d == SQ_IDLE && sq_q != SQ_IDLE) begin
        busy_q <= 1'b0;
      end
      if (apb_wr && paddr == REG_ADDR && !busy_q) addr_q <= pwdata[18:0];
      if (apb_wr && paddr == REG_WDATA && !busy_q) wdata_q <= pwdata[15:0];
      if (sq_q == SQ_CYC2 && eng_done && second_is_rd) rdata_q <= eng_rdata;
      if (sq_q == SQ_CHECK) begin
        fsr_q <= eng_rdata[7:0];
        if (dev_ready) err_q <= any_err;
      end
    end
  end

  // ****************************************************************
  // Flash cycle engine and pins
  // ****************************************************************
  flash_cycle_engine u_cycle (
    .clock   (clock),
    .nrst    (nrst),
    .req     (eng_req),
    .cyc     (cyc),
    .done    (eng_done),
    .rdata_q (eng_rdata),
    .pins    (pins),
    .dq_sync (dq_q)
  );

  assign ce_n              = pins.ce_n;
  assign oe_n              = pins.oe_n;
  assign we_n              = pins.we_n;
  assign flash_addr        = pins.addr;
  assign dq_o              = pins.dq_out;
  assign dq_oe             = pins.dq_oe;
  assign reset_powerdown_n = nrst;

endmodule
`default_nettype wire

/* shared/flash_host_pkg.sv */
// Purpose: constants and carriers for the parallel flash host controller
// Assumes: 16-bit word-mode flash with asynchronous strobes
// Notes:   device offsets are word addresses on the flash address pins
package flash_host_pkg;

  // ****************************************************************
  // Flash command codes
  // ****************************************************************
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT  = 8'h10;

  // ****************************************************************
  // Device identifier map (word addresses)
  // ****************************************************************
  localparam logic [18:0] ID_MAKER_ADDR    = 19'h00000;
  localparam logic [18:0] ID_PART_ADDR     = 19'h00001;
  localparam logic [18:0] ID_BLOCK_LOCK_OFS = 19'h00002;
  localparam logic [18:0] ID_DEV_LOCK_ADDR = 19'h00003;

  // ****************************************************************
  // Flash status byte fields
  // ****************************************************************
  localparam int SR_READY_BIT  = 7;
  localparam int SR_ERASE_BIT  = 5;
  localparam int SR_PROG_BIT   = 4;
  localparam int SR_SUPPLY_BIT = 3;
  localparam int SR_LOCK_BIT   = 1;

  // ****************************************************************
  // Own APB register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_FSR    = 8'h14;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 31;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ****************************************************************
  // Timing counts at 100 MHz
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STROBE_LOW_NS  = 70;
  localparam int STROBE_HIGH_NS = 30;
  localparam int STROBE_LOW_CYC =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC =
    (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Host operations
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ_ARRAY   = 3'h0,
    OP_READ_ID      = 3'h1,
    OP_READ_STATUS  = 3'h2,
    OP_CLEAR_STATUS = 3'h3,
    OP_BLOCK_ERASE  = 3'h4,
    OP_CHIP_ERASE   = 3'h5,
    OP_PROGRAM      = 3'h6,
    OP_RAW_WRITE    = 3'h7
  } op_e;

  // Single bus cycle request to the strobe engine
  typedef struct packed {
    logic        write;
    logic [18:0] addr;
    logic [15:0] data;
  } cycle_s;

  // Flash pin bundle driven by the host
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } flash_pins_s;

endpackage

/* testbench/flash_dev_model.sv */
// Purpose: behavioural parallel flash for the host bench
// Assumes: 8 blocks on addr[18:16], block 0 is the boot block
// Notes:   keeps two words a block; no suspend, no block ever fails
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int         BUSY_NS = 400,
  parameter logic [7:0] MAKER   = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART    = 8'h3c  // Arbitrary value
) (
  // Strobes and address
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [18:0] addr,
  // Data
  input  wire logic [15:0] din,
  output logic [15:0]      dout,
  // Board conditions
  input  wire logic        rp_n,
  input  wire logic        supply_ok,
  input  wire logic        wp,
  input  wire logic [7:0]  lock,
  output logic             ready_busy_out
);
  logic [7:0]  sr, setup, lat, f;
  logic [1:0]  mode;
  logic [15:0] mem [16];
  wire  [7:0]  okm = ~lock & {7'h7f, wp};
  wire  [3:0]  wi  = {addr[18:16], addr[0]};
  wire  [15:0] idv = addr == ID_MAKER_ADDR ? {8'h00, MAKER}
    : addr == ID_PART_ADDR ? {8'h00, PART}
    : addr == ID_DEV_LOCK_ADDR ? 16'h0001
    : addr[15:0] == ID_BLOCK_LOCK_OFS[15:0] ? {15'h0, lock[addr[18:16]]}
    : 16'h0000;
  wire  [15:0] val = mode == 2'd1 ? idv : mode == 2'd2 ? {8'h00, lat}
    : mem[wi];
  wire         rd  = !ce_n && !oe_n;
  wire         wr  = ce_n | we_n;
  // No pull on data: an idle bus shows garbage, not the last word
  assign dout = rd ? val : ~val;
  always @(negedge (ce_n | oe_n)) lat = sr;
  task automatic run();
    ready_busy_out = 1'b0;
    sr[7] = 1'b0;
    #BUSY_NS;
    sr[7] = 1'b1;
    ready_busy_out = 1'b1;
  endtask
  initial begin
    sr = 8'h80;
    setup = 8'h00;
    ready_busy_out = 1'b1;
    foreach (mem[i]) mem[i] = 16'hffff;
    mode = 2'd0;
  end
  always @(negedge rp_n) begin
    mode = 2'd0;
    setup = 8'h00;
  end
  always @(posedge wr) if (rp_n && (sr[7] || din[7:0] == CMD_READ_STATUS))
  begin
    f = setup;
    setup = 8'h00;
    if (f != 8'h00) mode = 2'd2;
    if (f == CMD_BLOCK_ERASE || f == CMD_CHIP_ERASE) begin
      if (din[7:0] != CMD_CONFIRM) sr |= 8'h30;
      else if (!supply_ok) sr |= 8'h28;
      else if (f == CMD_BLOCK_ERASE && !okm[addr[18:16]]) sr |= 8'h22;
      else if (okm == 8'h00) sr |= 8'h22;
      else begin
        for (int b = 0; b < 8; b++)
          if (okm[b] && (f == CMD_CHIP_ERASE || b[2:0] == addr[18:16])) begin
            mem[{b[2:0], 1'b0}] = 16'hffff;
            mem[{b[2:0], 1'b1}] = 16'hffff;
          end
        fork run(); join_none
      end
    end else if (f == CMD_PROGRAM || f == CMD_PROGRAM_ALT) begin
      if (!supply_ok) sr |= 8'h18;
      else if (!okm[addr[18:16]]) sr |= 8'h12;
      else begin
        mem[wi] = mem[wi] & din;
        fork run(); join_none
      end
    end else case (din[7:0])
      CMD_READ_ID: mode = 2'd1;
      CMD_READ_STATUS: mode = 2'd2;
      CMD_CLEAR_STATUS: sr &= 8'hc5;
      CMD_READ_ARRAY: mode = 2'd0;
      CMD_BLOCK_ERASE, CMD_CHIP_ERASE, CMD_PROGRAM, CMD_PROGRAM_ALT:
        setup = din[7:0];
      default: mode = mode;
    endcase
  end
endmodule
`default_nettype wire

/* testbench/flash_host_bench.sv */
// Purpose: self-checking bench for the flash host
// Assumes: device model on the far side, APB master here
// Notes:   seed fixed at 34
`timescale 1ns/1ns
`default_nettype none
module flash_host_bench;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, perr;
  logic ce_n, oe_n, we_n, dq_oe, rdy, rp_n, supply_ok, wp;
  logic [7:0]  paddr, lock;
  logic [31:0] pwdata, prdata, r;
  logic [18:0] fa, a;
  logic [15:0] dq_o, dq_dev, d, d2;
  int          seed, cycles, err_count, compares, n;
  logic [18:0] ida [5] = '{19'h0, 19'h1, 19'h3, 19'h20002, 19'h10002};
  logic [31:0] ide [5] = '{{24'h0, MAKER}, {24'h0, PART}, 1, 1, 0};
  wire  [15:0] dq_bus = dq_oe ? dq_o : dq_dev;
  flash_host dut_u (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .flash_addr(fa), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_bus), .ready_busy_out(rdy), .reset_powerdown_n(rp_n)
  );
  flash_dev_model #(.MAKER(MAKER), .PART(PART)) dev_u (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .din(dq_bus),
    .dout(dq_dev), .rp_n(rp_n), .supply_ok(supply_ok), .wp(wp),
    .lock(lock), .ready_busy_out(rdy)
  );
  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input op_e o, input logic [18:0] fad, input logic [15:0] wd);
    int k;
    apb(1'b1, REG_ADDR, {13'h0, fad});
    apb(1'b1, REG_WDATA, {16'h0, wd});
    apb(1'b1, REG_CTRL, {1'b1, 28'h0, o});
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 3000);
    if (r[0] !== 1'b0) begin
      err_count++;
      $display("mismatch at %0t: operation stuck busy", $time);
    end
  endtask
  task automatic rd_op(input op_e o, input logic [18:0] fad);
    op(o, fad, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask
  function automatic logic [31:0] fsr(input logic [7:0] fl);
    return {24'h0, 8'h80 | fl};
  endfunction
  // Run the op, check flags and error summary, then clear
  task automatic err_case(input op_e o, input logic [18:0] fad,
                          input logic [15:0] wd, input logic [7:0] fl);
    op(o, fad, wd);
    apb(1'b0, REG_FSR, 32'h0);
    chk(r, fsr(fl));
    apb(1'b0, REG_STATUS, 32'h0);
    chk({29'h0, r[2:0]}, {29'h0, 1'b1, fl != 8'h00, 1'b0});
    op(OP_CLEAR_STATUS, 19'h0, 16'h0);
  endtask
  // ****************
  // Clock, timeout, sequence
  // ****************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      $display("mismatch at %0t: timed out", $time);
      report_and_stop();
    end
  end
  initial begin
    seed = 34;
    cycles = 0;
    err_count = 0;
    compares = 0;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_ok, wp, lock} = {2'b11, 8'h04};
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, REG_RDATA, 32'h0);
    chk(r, RESET_WORD);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk({31'h0, perr}, 32'h1);
    repeat (4) begin
      a = 19'($random(seed));
      apb(1'b1, REG_ADDR, {13'h0, a});
      apb(1'b0, REG_ADDR, 32'h0);
      chk(r, {13'h0, a});
    end
    foreach (ida[i]) begin
      rd_op(OP_READ_ID, ida[i]);
      chk(r, ide[i]);
    end
    rd_op(OP_READ_STATUS, 19'h0);
    chk(r, 32'h80);
    a[18:16] = 3'h1;
    d = 16'($random(seed));
    d2 = 16'($random(seed));
    err_case(OP_PROGRAM, a, d, 8'h00);
    err_case(OP_PROGRAM, a, d2, 8'h00);
    rd_op(OP_READ_ARRAY, a);
    chk(r, {16'h0, d & d2});
    err_case(OP_BLOCK_ERASE, a, 16'h0, 8'h00);
    rd_op(OP_READ_ARRAY, a);
    chk(r, 32'hffff);
    op(OP_BLOCK_ERASE, 19'h20000, 16'h0);
    op(OP_PROGRAM, 19'h20001, 16'h0);
    apb(1'b0, REG_FSR, 32'h0);
    chk(r, fsr(8'h32));
    op(OP_CLEAR_STATUS, 19'h0, 16'h0);
    rd_op(OP_READ_STATUS, 19'h0);
    chk(r, 32'h80);
    wp <= 1'b0;
    err_case(OP_BLOCK_ERASE, 19'h0, 16'h0, 8'h22);
    err_case(OP_PROGRAM, 19'h4, 16'h0, 8'h12);
    {wp, supply_ok} <= 2'b10;
    err_case(OP_BLOCK_ERASE, a, 16'h0, 8'h28);
    err_case(OP_PROGRAM, a, d, 8'h18);
    err_case(OP_CHIP_ERASE, a, 16'h0, 8'h28);
    {supply_ok, lock} <= {1'b1, 8'hff};
    err_case(OP_CHIP_ERASE, a, 16'h0, 8'h22);
    lock <= 8'h04;
    for (int i = 0; i < 2; i++) begin
      op(OP_RAW_WRITE, a, {8'h0, i ? CMD_CHIP_ERASE : CMD_BLOCK_ERASE});
      op(OP_RAW_WRITE, a, 16'h0055);
      rd_op(OP_READ_STATUS, 19'h0);
      chk(r, 32'hb0);
      op(OP_CLEAR_STATUS, 19'h0, 16'h0);
    end
    op(OP_RAW_WRITE, a, {8'h0, CMD_PROGRAM_ALT});
    op(OP_RAW_WRITE, a, 16'h0);
    n = 0;
    do begin
      rd_op(OP_READ_STATUS, a);
      n++;
    end while (r[7] !== 1'b1 && n < 100);
    chk(r, 32'h80);
    rd_op(OP_READ_ARRAY, a);
    chk(r, 32'h0);
    err_case(OP_PROGRAM, 19'h30001, d, 8'h00);
    err_case(OP_CHIP_ERASE, 19'h0, 16'h0, 8'h00);
    rd_op(OP_READ_ARRAY, 19'h30001);
    chk(r, 32'hffff);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* testbench/flash_host_chk.sv */
// Purpose: pin timing checks on the flash host
// Assumes: one clock domain, nrst active low
// Notes:   sees the design's ports only
`timescale 1ns/1ns
`default_nettype none
module flash_host_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Flash pins
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe,
  input wire logic        reset_powerdown_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence rd_low;
    (!oe_n && !ce_n && !dq_oe)[*7] ##1 oe_n;
  endsequence
  sequence wr_low;
    (!we_n && !ce_n && dq_oe)[*7] ##1 we_n;
  endsequence
  a_read_width:
    assert property ($fell(oe_n) |-> rd_low) else $error("bad read width");
  a_write_width:
    assert property ($fell(we_n) |-> wr_low) else $error("bad write width");
  a_strobe_gap:
    assert property ($rose(ce_n) |-> ce_n[*3]) else $error("short gap");
  a_write_hold:
    assert property (!we_n && !$past(we_n) |-> $stable(dq_o)
      && $stable(flash_addr)) else $error("write data moved");
  a_latch_hold:
    assert property ($rose(we_n) |-> dq_oe && $stable(dq_o))
      else $error("data gone at latch edge");
  a_no_clash:
    assert property (!oe_n |-> we_n) else $error("read and write strobes");
  a_idle_quiet:
    assert property (ce_n |-> oe_n && we_n) else $error("strobe unselected");
  a_reset_pin:
    assert property (disable iff (1'b0) reset_powerdown_n == nrst)
      else $error("reset pin does not follow reset");
endmodule
bind flash_host flash_host_chk chk_u (
  .clock(clock), .nrst(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe),
  .reset_powerdown_n(reset_powerdown_n)
);
`default_nettype wire
